// >>> inc/gpio_pkg.sv
// constants and types for the gpio function, bit-operation and speed registers
package gpio_pkg;
   // bus shape
   localparam int ADDR_W    = 12;
   localparam int DATA_W    = 32;
   localparam int STRB_W    = 4;
   // port shape
   localparam int PIN_N     = 16;
   localparam int UPPER_N   = 8;
   localparam int CODE_W    = 4;
   localparam int FUNC_N    = 8;
   localparam int SPEED_W   = 2;
   // register byte addresses
   localparam logic [ADDR_W-1:0] UPPER_PIN_FUNCTION_SELECT_OFS = 12'h024;
   localparam logic [ADDR_W-1:0] OUTPUT_BIT_CLEAR_OFS          = 12'h028;
   localparam logic [ADDR_W-1:0] OUTPUT_BIT_TOGGLE_OFS         = 12'h02c;
   localparam logic [ADDR_W-1:0] VERY_HIGH_SPEED_FLAGS_OFS     = 12'h03c;
   // reset values
   localparam logic [DATA_W-1:0] UPPER_PIN_FUNCTION_SELECT_RST = 32'h0000_0000;
   localparam logic [PIN_N-1:0]  VERY_HIGH_SPEED_FLAGS_RST     = 16'h0000;
   localparam logic [PIN_N-1:0]  OUTPUT_LEVEL_RST              = 16'h0000;
   localparam logic [DATA_W-1:0] WRITE_ONLY_READ_VALUE         = 32'h0000_0000;
   // pin function codes
   localparam logic [CODE_W-1:0] ALTERNATE_FUNCTION_ZERO       = 4'h0;
   localparam logic [CODE_W-1:0] FIRST_HIGH_FUNCTION_CODE      = 4'h4;
   localparam logic [CODE_W-1:0] FIRST_RESERVED_CODE           = 4'h8;
   // speed field value that lets the very-high-speed flag act
   localparam logic [SPEED_W-1:0] FASTEST_SPEED_FIELD          = 2'h3;
   localparam logic [STRB_W-1:0]  FULL_WORD_STROBE             = 4'hf;
   typedef logic [CODE_W-1:0] pin_function_code_t;
   typedef enum logic [1:0] {
      bus_idle   = 2'b01,
      bus_answer = 2'b10
   } bus_state_t;
endpackage : gpio_pkg

// >>> inc/pin_function_if.sv
// carrier between the function register and one pin's function decoder
`timescale 1ns/1ps
interface pin_function_if;
   import gpio_pkg::*;
   pin_function_code_t  code;
   logic                high_allowed;
   logic [FUNC_N-1:0]   enable;
   modport owner   (output code, output high_allowed, input enable);
   modport decoder (input code, input high_allowed, output enable);
endinterface : pin_function_if

// >>> rtl/gpio_upper_regs.sv
// function select, bit clear, bit toggle and very-high-speed registers on apb
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
// Function
// - codes 0000 to 0111 route a pin 8..15 to alternate function 0..7
// - functions 4 to 7 act only on ports that have them
// - pin 15 sits in bits 31:28 down to pin 8 in bits 3:0
// - select, clear and toggle take byte, half-word or word writes; word reads
// - a one written to a clear bit drives that output level bit low
// - a one written to a toggle bit inverts that output level bit
// - a speed flag gives very high speed only while its speed field is 0b11
// - after reset the function register reads zero; enables are all off until the first clock, then all pins on function zero
module gpio_upper_regs #(
   parameter bit HIGH_FUNCTIONS_PRESENT = 1'b1
) (
   // clock and reset
   input  wire logic                                       clk,
   input  wire logic                                       rst,
   // apb slave
   input  wire logic                                       psel,
   input  wire logic                                       penable,
   input  wire logic                                       pwrite,
   input  wire logic [gpio_pkg::ADDR_W-1:0]                paddr,
   input  wire logic [gpio_pkg::DATA_W-1:0]                pwdata,
   input  wire logic [gpio_pkg::STRB_W-1:0]                pstrb,
   output logic      [gpio_pkg::DATA_W-1:0]                prdata,
   output logic                                            pready,
   output logic                                            pslverr,
   // output level from the port's own control register
   input  wire logic                                       level_load,
   input  wire logic [gpio_pkg::PIN_N-1:0]                 level_value,
   output logic      [gpio_pkg::PIN_N-1:0]                 output_level,
   // speed
   input  wire logic [gpio_pkg::PIN_N*gpio_pkg::SPEED_W-1:0] output_speed_field,
   output logic      [gpio_pkg::PIN_N-1:0]                 very_high_speed_active,
   // alternate function enables, eight per upper pin, pin 8 lowest
   output logic      [gpio_pkg::UPPER_N*gpio_pkg::FUNC_N-1:0] pin_function_enable
);
   import gpio_pkg::*;

   bus_state_t                    state;
   bus_state_t                    next_state;
   logic [DATA_W-1:0]             upper_pin_function_select;
   logic [PIN_N-1:0]              very_high_speed_flags;
   logic [DATA_W-1:0]             lane_mask;
   logic                          setup;
   logic                          fire_write;
   logic                          hit_select;
   logic                          hit_clear;
   logic                          hit_toggle;
   logic                          hit_speed;
   logic                          mapped;
   logic [DATA_W-1:0]             read_value;
   logic [DATA_W-1:0]             next_select;
   logic [PIN_N-1:0]              next_speed;
   logic [PIN_N-1:0]              clear_bits;
   logic [PIN_N-1:0]              toggle_bits;
   logic [PIN_N-1:0]              loaded_level;
   logic [PIN_N-1:0]              next_level;
   logic [PIN_N-1:0]              next_fast;
   logic [UPPER_N*FUNC_N-1:0]     next_enable;

   // bus handshake: one answer cycle after every setup
   assign setup      = psel && !penable && (state == bus_idle);
   assign fire_write = psel && penable && pready && pwrite;
   assign next_state = setup ? bus_answer : bus_idle;

   // address decode
   assign hit_select = (paddr == UPPER_PIN_FUNCTION_SELECT_OFS);
   assign hit_clear  = (paddr == OUTPUT_BIT_CLEAR_OFS);
   assign hit_toggle = (paddr == OUTPUT_BIT_TOGGLE_OFS);
   assign hit_speed  = (paddr == VERY_HIGH_SPEED_FLAGS_OFS);
   assign mapped     = hit_select || hit_clear || hit_toggle || hit_speed;

   // byte lanes from the write strobes
   genvar g;
   generate
      for (g = 0; g < STRB_W; g++) begin : g_lane
         assign lane_mask[g*8 +: 8] = {8{pstrb[g]}};
      end
   endgenerate

   // read mux, reads are whole words
   assign read_value = hit_select ? upper_pin_function_select :
                       hit_speed  ? {{(DATA_W-PIN_N){1'b0}}, very_high_speed_flags} :
                       WRITE_ONLY_READ_VALUE;

   // function select with byte, half-word or word writes
   assign next_select = (fire_write && hit_select) ?
                        ((upper_pin_function_select & ~lane_mask) | (pwdata & lane_mask)) :
                        upper_pin_function_select;

   // speed flags take whole-word writes only
   assign next_speed = (fire_write && hit_speed && (pstrb == FULL_WORD_STROBE)) ?
                       pwdata[PIN_N-1:0] : very_high_speed_flags;

   // clear and toggle act on the level in the write cycle and keep nothing
   assign clear_bits   = (fire_write && hit_clear)  ? (pwdata[PIN_N-1:0] & lane_mask[PIN_N-1:0]) : '0;
   assign toggle_bits  = (fire_write && hit_toggle) ? (pwdata[PIN_N-1:0] & lane_mask[PIN_N-1:0]) : '0;
   assign loaded_level = level_load ? level_value : output_level;
   assign next_level   = (loaded_level & ~clear_bits) ^ toggle_bits;

   // per pin speed qualification and per upper pin function decode
   generate
      for (g = 0; g < PIN_N; g++) begin : g_speed
         assign next_fast[g] = very_high_speed_flags[g] &&
                               (output_speed_field[g*SPEED_W +: SPEED_W] == FASTEST_SPEED_FIELD);
      end
      for (g = 0; g < UPPER_N; g++) begin : g_pin
         pin_function_if pf ();
         assign pf.code         = upper_pin_function_select[g*CODE_W +: CODE_W];
         assign pf.high_allowed = HIGH_FUNCTIONS_PRESENT;
         assign next_enable[g*FUNC_N +: FUNC_N] = pf.enable;
         pin_function_decode u_decode (
            .pf (pf.decoder)
         );
      end
   endgenerate

   // bus answer registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state   <= bus_idle;
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else begin
         state   <= next_state;
         pready  <= setup;
         pslverr <= setup && !mapped;
         prdata  <= (setup && !pwrite) ? read_value : '0;
      end
   end

   // stored registers and port outputs
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         upper_pin_function_select <= UPPER_PIN_FUNCTION_SELECT_RST;
         very_high_speed_flags     <= VERY_HIGH_SPEED_FLAGS_RST;
         output_level              <= OUTPUT_LEVEL_RST;
         very_high_speed_active    <= '0;
         pin_function_enable       <= '0;
      end else begin
         upper_pin_function_select <= next_select;
         very_high_speed_flags     <= next_speed;
         output_level              <= next_level;
         very_high_speed_active    <= next_fast;
         pin_function_enable       <= next_enable;
      end
   end
endmodule : gpio_upper_regs

// >>> rtl/pin_function_decode.sv
// decodes one pin function code into a one-hot alternate function enable
`timescale 1ns/1ps
module pin_function_decode (
   // code in, enables out
   pin_function_if.decoder pf
);
   import gpio_pkg::*;
   logic                code_reserved;
   logic                code_high;
   logic                code_usable;
   logic [FUNC_N-1:0]   one_hot;
   assign code_reserved = (pf.code >= FIRST_RESERVED_CODE);
   assign code_high     = (pf.code >= FIRST_HIGH_FUNCTION_CODE);
   assign code_usable   = !code_reserved && (!code_high || pf.high_allowed);
   assign one_hot       = FUNC_N'(1) << pf.code[2:0];
   assign pf.enable     = code_usable ? one_hot : '0;
endmodule : pin_function_decode

// >>> tb/gpio_pins_model.sv
// pin side model: output level loads and speed fields
`timescale 1ns/1ps
module gpio_pins_model (
   // control from bench, outputs to block
   input  wire logic        clk, load_en,
   output logic             level_load,
   output logic [15:0]      level_value,
   output logic [31:0]      output_speed_field
);
   logic [31:0] s = 32'h5a5a_1234;
   initial {level_load, level_value, output_speed_field} = '0;
   always @(posedge clk) begin
      s <= {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
      level_load <= load_en & s[3];
      level_value <= s[15:0];
      output_speed_field <= s | {16{s[9], s[4]}};
   end
endmodule : gpio_pins_model

// >>> tb/gpio_upper_regs_checker.sv
// port assertions for the gpio register block
`timescale 1ns/1ps
module gpio_upper_regs_checker import gpio_pkg::*; #(parameter bit HIGH_FUNCTIONS_PRESENT = 1'b1) (
   // bus, level and speed ports
   input wire logic                    clk, rst, psel, penable, pwrite, pready, pslverr, level_load,
   input wire logic [ADDR_W-1:0]       paddr,
   input wire logic [DATA_W-1:0]       pwdata, prdata,
   input wire logic [STRB_W-1:0]       pstrb,
   input wire logic [PIN_N-1:0]        level_value, output_level, very_high_speed_active,
   input wire logic [PIN_N*SPEED_W-1:0] output_speed_field,
   input wire logic [UPPER_N*FUNC_N-1:0] pin_function_enable
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire logic        acc  = psel && penable && pready;
   wire logic [15:0] lane = {{8{pstrb[1]}}, {8{pstrb[0]}}} & pwdata[15:0];
   logic [15:0]      fast;
   logic [63:0]      exp_en;
   always_comb for (int i = 0; i < 16; i++) fast[i] = output_speed_field[2*i +: 2] == FASTEST_SPEED_FIELD;
   always_comb for (int i = 0; i < 64; i++)
      exp_en[i] = prdata[4*(i/8) +: 4] == 4'(i%8) && (i%8 < 4 || HIGH_FUNCTIONS_PRESENT);
   a_ready_next:
      assert property (psel && !penable |=> pready) else $error("no ready after setup");
   a_ready_pulse:
      assert property (pready |=> !pready) else $error("ready held");
   a_clear_bits:
      assert property (acc && pwrite && paddr == OUTPUT_BIT_CLEAR_OFS && !level_load |=>
         output_level == ($past(output_level) & ~$past(lane))) else $error("clear wrong");
   a_toggle_bits:
      assert property (acc && pwrite && paddr == OUTPUT_BIT_TOGGLE_OFS && !level_load |=>
         output_level == ($past(output_level) ^ $past(lane))) else $error("toggle wrong");
   a_speed_gate:
      assert property ((very_high_speed_active & ~$past(fast)) == 16'h0) else $error("speed ungated");
   a_func_map:
      assert property (pready && !pwrite && paddr == UPPER_PIN_FUNCTION_SELECT_OFS |->
         pin_function_enable == exp_en) else $error("function enables wrong");
   a_wo_zero:
      assert property (pready && !pwrite && (paddr == OUTPUT_BIT_CLEAR_OFS || paddr == OUTPUT_BIT_TOGGLE_OFS)
         |-> prdata == WRITE_ONLY_READ_VALUE) else $error("write-only read not zero");
   a_level_hold:
      assert property (!acc && !level_load |=> $stable(output_level)) else $error("level moved");
   c_clear: cover property (acc && pwrite && paddr == OUTPUT_BIT_CLEAR_OFS);
   c_toggle: cover property (acc && pwrite && paddr == OUTPUT_BIT_TOGGLE_OFS);
   c_error: cover property (pslverr);
endmodule : gpio_upper_regs_checker
bind gpio_upper_regs gpio_upper_regs_checker #(.HIGH_FUNCTIONS_PRESENT(HIGH_FUNCTIONS_PRESENT)) chk (.*);

// >>> tb/gpio_upper_regs_tb_top.sv
// self-checking bench for the gpio register block
`timescale 1ns/1ps
module gpio_upper_regs_tb_top;
   import gpio_pkg::*;
   logic              clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, load_en = 0, pready, pslverr, err;
   logic [11:0]       paddr = '0;
   logic [31:0]       pwdata = '0, prdata, rd, d, sel_m = 0, output_speed_field, r = 32'hab86dc20;
   logic [3:0]        pstrb = '0;
   logic [15:0]       level_value, output_level, very_high_speed_active, lvl = 0, m, fast;
   logic              level_load;
   logic [63:0]       pin_function_enable;
   int                fails = 0, checks_done = 0;
   gpio_upper_regs dut (.*);
   gpio_pins_model pins (.*);
   initial forever #5 clk = ~clk;
   function automatic logic [31:0] lfsr(logic [31:0] v);
      for (int i = 0; i < 32; i++) v = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
      return v;
   endfunction : lfsr
   task automatic check(logic [31:0] seen, logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic stop_test;
      if (fails == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : stop_test
   task automatic apb(logic w, logic [11:0] a, logic [31:0] dat, logic [3:0] s);
      @(posedge clk);
      {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, dat, s};
      @(posedge clk);
      penable <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      {rd, err} = {prdata, pslverr};
      {psel, penable} <= 2'b00;
   endtask : apb
   initial begin
      repeat (4) @(posedge clk);
      rst <= 0;
      apb(0, UPPER_PIN_FUNCTION_SELECT_OFS, 0, 0); check(rd, 0);
      apb(0, VERY_HIGH_SPEED_FLAGS_OFS, 0, 0); check(rd, 0);
      for (int i = 0; i < 30; i++) begin
         r = lfsr(r); d = lfsr(r) & 32'h7777_7777;
         apb(1, UPPER_PIN_FUNCTION_SELECT_OFS, d, r[3:0]);
         for (int b = 0; b < 4; b++) if (r[b]) sel_m[8*b +: 8] = d[8*b +: 8];
         apb(0, UPPER_PIN_FUNCTION_SELECT_OFS, 0, 0); check(rd, sel_m);
      end
      for (int i = 0; i < 40; i++) begin
         r = lfsr(r); d = lfsr(r) & 32'hffff;
         apb(1, r[4] ? OUTPUT_BIT_TOGGLE_OFS : OUTPUT_BIT_CLEAR_OFS, d, r[3:0]);
         m = d[15:0] & {{8{r[1]}}, {8{r[0]}}};
         lvl = r[4] ? lvl ^ m : lvl & ~m;
         @(negedge clk) check(output_level, lvl);
      end
      apb(0, OUTPUT_BIT_CLEAR_OFS, 0, 0); check(rd, 0);
      apb(0, OUTPUT_BIT_TOGGLE_OFS, 0, 0); check(rd, 0);
      d = lfsr(r) & 32'hffff;
      apb(1, VERY_HIGH_SPEED_FLAGS_OFS, d, 4'hf);
      apb(1, VERY_HIGH_SPEED_FLAGS_OFS, ~d & 32'hffff, 4'h3);
      apb(0, VERY_HIGH_SPEED_FLAGS_OFS, 0, 0); check(rd, d);
      for (int i = 0; i < 20; i++) begin
         @(negedge clk) for (int y = 0; y < 16; y++) fast[y] = output_speed_field[2*y +: 2] == 2'b11;
         @(negedge clk) check(very_high_speed_active, d[15:0] & fast);
      end
      apb(0, 12'h030, 0, 0); check(err, 1);
      load_en <= 1;
      for (int i = 0; i < 20; i++) begin
         r = lfsr(r);
         apb(1, OUTPUT_BIT_TOGGLE_OFS, r & 32'hffff, 4'hf);
         lvl = (level_load ? level_value : output_level) ^ r[15:0];
         @(negedge clk) check(output_level, lvl);
      end
      stop_test;
   end
   initial begin
      #100us;
      fails++;
      stop_test;
   end
endmodule : gpio_upper_regs_tb_top
